// ### common/sdhi_defs.vh
// constants of the card host interface
`ifndef SDHI_DEFS_VH
`define SDHI_DEFS_VH
// register word indices, byte address is four times the index
`define SDHI_IDX_PTR 16'hFC7C
`define SDHI_IDX_LEN 16'hFC7D
`define SDHI_IDX_CFG 16'hFC7E
`define SDHI_IDX_ST 16'hFC7F
`define SDHI_IDX_IRQ 16'hFC6C
// reset values
`define SDHI_RST_PTR 11'h000
`define SDHI_RST_LEN 16'h0000
`define SDHI_RST_CFG 16'h0000
`define SDHI_RST_WS 5'h00
// writable configuration bits
`define SDHI_CFG_MASK 16'h1C7F
// configuration fields
`define SDHI_CF_SKIPCRC 12
`define SDHI_CF_KEEPCRC 11
`define SDHI_CF_WIDE 10
`define SDHI_CF_LAUNCH 7
`define SDHI_CF_READ 6
`define SDHI_CF_CMD 5
`define SDHI_CF_NOSTART 4
`define SDHI_CF_NOSTOP 3
`define SDHI_CF_CRC16 2
`define SDHI_CF_CRC7 1
`define SDHI_CF_HUNT 0
// status fields
`define SDHI_ST_WS_HI 12
`define SDHI_ST_WS_LO 8
`define SDHI_ST_REP 7
// buffer interrupt status fields
`define SDHI_IRQ_ENA 14
`define SDHI_IRQ_READY 5
// timing and framing counts
`define SDHI_HUNT_CLKS 8'hFF
`define SDHI_CRC7_LEN 5'h07
`define SDHI_CRC16_LEN 5'h10
`define SDHI_CRC7_POLY 7'h09
`define SDHI_CRC16_POLY 16'h1021
`endif

// ### logic/sdhi_top.v
// card host interface: register slave, bit engine and buffer port
//
// Contract
// R1: data moves on one line, or on four when wide bus bit 10 set
// R2: buffer pointer is an 11-bit word address into peripheral memory
// R3: transfer length counts bytes read from or written to card
// R4: config bit 7 launches one transfer using the other config bits
// R5: config bit 6 set means read from card, clear means write
// R6: config bit 5 set selects command line, clear selects data lines
// R7: config bit 4 omits the start bit
// R8: config bit 3 omits the stop bit
// R9: bits 2 and 1 enable crc16 and crc7, sent after payload
// R10: config bit 12 skips sending the checksum
// R11: config bit 11 keeps checksum accumulator from previous transfer
// R12: with hunt bit 0, no start bit in 256 card clocks aborts, flags
// R13: card clock period is 2 x (divider field + 1) system cycles
// R14: status bit 7 replays a 512-byte buffer, base from pointer 10:8
// R15: software clears other bits in pattern mode except divider, width
// R16: status bit 5 flags command start during data, cleared on launch
// R17: status bit 4 shows sampled level of data line zero
// R18: status bit 3 flags read data ending without stop bit
// R19: status bit 2 flags crc16 failure on data read
// R20: status bit 1 flags crc7 failure on command response
// R21: completion sets ready request bit 5, forwarded when bit 14 set
// R22: writing one to ready bit clears it, zero leaves it
// R23: card clock stops and engine idles after frame end or abort
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`include "sdhi_defs.vh"
module sdhi_top (
  input wire clk,
  input wire sys_rst,
  input wire [17:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [10:0] mem_addr,
  output reg mem_rd,
  output reg mem_wr,
  output reg [15:0] mem_wdata,
  input wire [15:0] mem_rdata,
  output reg sd_clk,
  input wire sd_cmd_in,
  output reg sd_cmd_out,
  output reg sd_cmd_oe_n,
  input wire [3:0] sd_dat_in,
  output reg [3:0] sd_dat_out,
  output reg [3:0] sd_dat_oe_n,
  output reg buffer_irq
);

// ----------------------------------------
// states
// ----------------------------------------
localparam S_IDLE = 3'd0;
localparam S_PREP = 3'd1;
localparam S_START = 3'd2;
localparam S_DATA = 3'd3;
localparam S_CRC = 3'd4;
localparam S_STOP = 3'd5;
localparam S_END = 3'd6;
localparam S_REP = 3'd7;

reg [2:0] st;
reg [10:0] ptr;
reg [15:0] len;
reg [15:0] cfg;
reg [4:0] ws;
reg rep;
reg irq_en;
reg ready_req;
reg cmdbrk;
reg e_stop;
reg e_c16;
reg e_c7;
reg e_start;

// ----------------------------------------
// pin synchronisers
// ----------------------------------------
reg [4:0] s1;
reg [4:0] s2;
reg [4:0] s3;
reg [4:0] filt;
always @(posedge clk) begin
  if (sys_rst) begin
    s1 <= 5'h1F;
    s2 <= 5'h1F;
    s3 <= 5'h1F;
    filt <= 5'h1F;
  end else begin
    s1 <= {sd_cmd_in, sd_dat_in};
    s2 <= s1;
    s3 <= s2;
    filt <= (s2 & s3) | (filt & ~(s2 ^ s3));
  end
end
wire fcmd = filt[4];
wire [3:0] fdat = filt[3:0];

// ----------------------------------------
// register slave
// ----------------------------------------
wire busy = (st != S_IDLE);
wire [15:0] wa = avs_address[17:2];
wire wr_acc = avs_write & ~avs_waitrequest;
wire [15:0] wd = avs_writedata[15:0];
wire [1:0] be = avs_byteenable[1:0];
wire launch = wr_acc & (wa == `SDHI_IDX_CFG) & be[0] & wd[`SDHI_CF_LAUNCH]
  & ~busy & ~rep; // R4
wire irq_clr = wr_acc & (wa == `SDHI_IDX_IRQ) & be[0] & wd[`SDHI_IRQ_READY];

function [15:0] mrg;
  input [15:0] o;
  input [15:0] n;
  input [1:0] b;
  begin
    mrg = {b[1] ? n[15:8] : o[15:8], b[0] ? n[7:0] : o[7:0]};
  end
endfunction
wire [15:0] ptr_m = mrg({5'h00, ptr}, wd, be);

wire [15:0] st_word = {3'b000, ws, rep, 1'b0, cmdbrk, fdat[0],
  e_stop, e_c16, e_c7, e_start}; // R17
wire [15:0] cfg_word = {cfg[15:8], busy, cfg[6:0]};
wire [15:0] irq_word = {1'b0, irq_en, 8'h00, ready_req, 5'h00};
reg [15:0] rd_word;
always @* begin
  case (wa)
    `SDHI_IDX_PTR: rd_word = {5'h00, ptr};
    `SDHI_IDX_LEN: rd_word = len;
    `SDHI_IDX_CFG: rd_word = cfg_word;
    `SDHI_IDX_ST: rd_word = st_word;
    `SDHI_IDX_IRQ: rd_word = irq_word;
    default: rd_word = 16'h0000;
  endcase
end

always @(posedge clk) begin
  if (sys_rst) begin
    avs_waitrequest <= 1'b1;
    avs_readdata <= 32'h00000000;
    ptr <= `SDHI_RST_PTR;
    len <= `SDHI_RST_LEN;
    cfg <= `SDHI_RST_CFG;
    ws <= `SDHI_RST_WS;
    rep <= 1'b0;
    irq_en <= 1'b0;
    buffer_irq <= 1'b0;
  end else begin
    avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    if (avs_read & avs_waitrequest)
      avs_readdata <= {16'h0000, rd_word};
    if (wr_acc) begin
      case (wa)
        `SDHI_IDX_PTR: ptr <= ptr_m[10:0]; // R2
        `SDHI_IDX_LEN: len <= mrg(len, wd, be); // R3
        `SDHI_IDX_CFG: if (!busy) cfg <= mrg(cfg, wd, be) & `SDHI_CFG_MASK;
        `SDHI_IDX_ST: begin
          if (be[1]) ws <= wd[`SDHI_ST_WS_HI:`SDHI_ST_WS_LO];
          if (be[0]) rep <= wd[`SDHI_ST_REP]; // R14
        end
        `SDHI_IDX_IRQ: if (be[1]) irq_en <= wd[`SDHI_IRQ_ENA];
        default: ;
      endcase
    end
    buffer_irq <= ready_req & irq_en; // R21
  end
end

// ----------------------------------------
// card clock divider
// ----------------------------------------
reg [4:0] dcnt;
reg lead;
wire clk_run = busy & (st != S_PREP);
wire expire = clk_run & (dcnt == ws); // R13
wire drv_ev = expire & (lead | sd_clk);
wire smp_ev = expire & ~lead & ~sd_clk;
wire c_rd = cfg[`SDHI_CF_READ] & ~rep; // R5
wire c_cmd = cfg[`SDHI_CF_CMD] & ~rep; // R6
wire tick = c_rd ? smp_ev : drv_ev;

// ----------------------------------------
// framing decisions
// ----------------------------------------
wire wide = cfg[`SDHI_CF_WIDE] & ~c_cmd; // R1
wire [2:0] nb = wide ? 3'd4 : 3'd1;
wire crc_on = c_cmd ? cfg[`SDHI_CF_CRC7] : cfg[`SDHI_CF_CRC16]; // R9
wire crc_go = crc_on & ~cfg[`SDHI_CF_SKIPCRC]; // R10
wire [2:0] after_crc = cfg[`SDHI_CF_NOSTOP] ? S_END : S_STOP; // R8
wire [2:0] after_data = crc_go ? S_CRC : after_crc;
reg [18:0] bleft;
wire [2:0] after_start = (bleft != 19'd0) ? S_DATA : after_data;
wire [3:0] lane_mask = wide ? 4'hF : 4'h1;

// ----------------------------------------
// shift paths and checksums
// ----------------------------------------
reg [15:0] sh;
reg [15:0] nxt;
reg sh_ok;
reg nxt_ok;
reg rd_p2;
reg [10:0] fa;
reg [4:0] wbit;
reg [15:0] rsh;
reg [4:0] rfill;
reg [4:0] ccnt;
reg [7:0] hcnt;
reg crc_bad;
reg [6:0] crc7;
wire line_in = c_cmd ? fcmd : fdat[0];
wire [3:0] lanes_in = wide ? fdat : {3'b000, line_in};
wire [3:0] lanes_out = wide ? sh[15:12] : {3'b000, sh[15]};
wire [3:0] lbit = c_rd ? lanes_in : lanes_out;
wire crc_clr = (st == S_PREP) & ~cfg[`SDHI_CF_KEEPCRC]; // R11
wire crc_upd = tick & (st == S_DATA);
wire crc_sh = tick & (st == S_CRC);
wire [3:0] crc_msb;
wire [15:0] rsh_n = wide ? {rsh[11:0], lanes_in} : {rsh[14:0], line_in};

genvar gi;
generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
    reg [15:0] c16;
    always @(posedge clk) begin
      if (sys_rst || crc_clr)
        c16 <= 16'h0000;
      else if (crc_upd)
        c16 <= {c16[14:0], 1'b0} ^ ((lbit[gi] ^ c16[15]) ? `SDHI_CRC16_POLY : 16'h0000);
      else if (crc_sh)
        c16 <= {c16[14:0], 1'b0};
    end
    assign crc_msb[gi] = c16[15];
  end
endgenerate

wire [3:0] crc_out = wide ? crc_msb : {3'b000, crc_msb[0]};
wire mism = c_cmd ? (line_in ^ crc7[6]) : |((lanes_in ^ crc_msb) & lane_mask);
wire [10:0] fa_inc = rep ? {fa[10:8], fa[7:0] + 8'h01} : fa + 11'h001;
wire fetch_ok = ~c_rd & ((st == S_PREP) | (st == S_DATA) | (st == S_REP))
  & ~(sh_ok & nxt_ok) & ~mem_rd & ~rd_p2;
wire word_end = (wbit == {2'b00, nb});

// ----------------------------------------
// bit engine
// ----------------------------------------
always @(posedge clk) begin
  if (sys_rst) begin
    st <= S_IDLE;
    sd_clk <= 1'b0;
    dcnt <= 5'h00;
    lead <= 1'b0;
    mem_addr <= 11'h000;
    mem_rd <= 1'b0;
    mem_wr <= 1'b0;
    mem_wdata <= 16'h0000;
    sd_cmd_out <= 1'b1;
    sd_cmd_oe_n <= 1'b1;
    sd_dat_out <= 4'hF;
    sd_dat_oe_n <= 4'hF;
    sh <= 16'h0000;
    nxt <= 16'h0000;
    sh_ok <= 1'b0;
    nxt_ok <= 1'b0;
    rd_p2 <= 1'b0;
    fa <= 11'h000;
    wbit <= 5'h00;
    rsh <= 16'h0000;
    rfill <= 5'h00;
    bleft <= 19'd0;
    ccnt <= 5'h00;
    hcnt <= 8'h00;
    crc_bad <= 1'b0;
    crc7 <= 7'h00;
    ready_req <= 1'b0;
    cmdbrk <= 1'b0;
    e_stop <= 1'b0;
    e_c16 <= 1'b0;
    e_c7 <= 1'b0;
    e_start <= 1'b0;
  end else begin
    mem_wr <= 1'b0;
    mem_rd <= 1'b0;
    rd_p2 <= mem_rd;
    if (irq_clr)
      ready_req <= 1'b0; // R22
    if (!clk_run || expire)
      dcnt <= 5'h00;
    else
      dcnt <= dcnt + 5'h01;
    if (expire && !lead)
      sd_clk <= ~sd_clk;
    if (crc_clr)
      crc7 <= 7'h00;
    if (fetch_ok) begin
      mem_rd <= 1'b1;
      mem_addr <= fa;
      fa <= fa_inc;
    end
    if (rd_p2) begin
      if (!sh_ok) begin
        sh <= mem_rdata;
        sh_ok <= 1'b1;
        wbit <= 5'h10;
      end else begin
        nxt <= mem_rdata;
        nxt_ok <= 1'b1;
      end
    end
    case (st)
      S_IDLE: begin
        sd_clk <= 1'b0;
        sh_ok <= 1'b0;
        nxt_ok <= 1'b0;
        if (launch || rep) begin
          st <= S_PREP;
          fa <= rep ? {ptr[10:8], 8'h00} : ptr; // R14
          bleft <= {len, 3'b000};
          rfill <= 5'h00;
          hcnt <= 8'h00;
          crc_bad <= 1'b0;
          if (launch) begin
            cmdbrk <= 1'b0; // R16
            e_stop <= 1'b0;
            e_c16 <= 1'b0;
            e_c7 <= 1'b0;
            e_start <= 1'b0;
          end
        end
      end
      S_PREP: begin
        ccnt <= c_cmd ? `SDHI_CRC7_LEN : `SDHI_CRC16_LEN;
        if (c_rd)
          st <= cfg[`SDHI_CF_NOSTART] ? after_start : S_START; // R7
        else if (sh_ok && nxt_ok) begin
          lead <= 1'b1;
          st <= rep ? S_REP : (cfg[`SDHI_CF_NOSTART] ? after_start : S_START); // R7
        end
      end
      default: ;
    endcase
    if (drv_ev)
      lead <= 1'b0;
    if (tick && !c_rd && st != S_IDLE && st != S_PREP) begin
      case (st)
        S_START: begin
          if (c_cmd) begin
            sd_cmd_out <= 1'b0;
            sd_cmd_oe_n <= 1'b0;
          end else begin
            sd_dat_out <= 4'h0;
            sd_dat_oe_n <= ~lane_mask;
          end
          st <= after_start;
        end
        S_DATA, S_REP: begin
          if (c_cmd) begin
            sd_cmd_out <= sh[15];
            sd_cmd_oe_n <= 1'b0;
            crc7 <= {crc7[5:0], 1'b0} ^ ((sh[15] ^ crc7[6]) ? `SDHI_CRC7_POLY : 7'h00);
          end else begin
            sd_dat_out <= lanes_out; // R1
            sd_dat_oe_n <= ~lane_mask;
          end
          sh <= sh << nb;
          wbit <= wbit - {2'b00, nb};
          if (word_end) begin
            sh <= nxt;
            wbit <= 5'h10;
            nxt_ok <= 1'b0;
            sh_ok <= nxt_ok;
          end
          if (st == S_DATA) begin
            bleft <= bleft - {16'd0, nb};
            if (bleft == {16'd0, nb})
              st <= after_data;
          end
        end
        S_CRC: begin
          if (c_cmd) begin
            sd_cmd_out <= crc7[6]; // R9
            crc7 <= {crc7[5:0], 1'b0};
          end else
            sd_dat_out <= crc_out; // R9
          ccnt <= ccnt - 5'h01;
          if (ccnt == 5'h01)
            st <= after_crc;
        end
        S_STOP: begin
          sd_cmd_out <= 1'b1;
          sd_dat_out <= 4'hF;
          st <= S_END;
        end
        default: ;
      endcase
    end
    if (tick && c_rd) begin
      case (st)
        S_START: begin
          if (!cfg[`SDHI_CF_HUNT] || !line_in)
            st <= after_start;
          else begin
            hcnt <= hcnt + 8'h01;
            if (hcnt == `SDHI_HUNT_CLKS) begin
              e_start <= 1'b1; // R12
              st <= S_IDLE; // R23
            end
          end
        end
        S_DATA: begin
          rsh <= rsh_n;
          if (c_cmd)
            crc7 <= {crc7[5:0], 1'b0} ^ ((line_in ^ crc7[6]) ? `SDHI_CRC7_POLY : 7'h00);
          bleft <= bleft - {16'd0, nb};
          rfill <= rfill + {2'b00, nb};
          if (rfill + {2'b00, nb} == 5'h10) begin
            mem_wr <= 1'b1;
            mem_addr <= fa;
            mem_wdata <= rsh_n;
            fa <= fa + 11'h001;
            rfill <= 5'h00;
          end
          if (bleft == {16'd0, nb}) begin
            st <= after_data;
            if (rfill + {2'b00, nb} == 5'h08) begin
              mem_wr <= 1'b1;
              mem_addr <= fa;
              mem_wdata <= {rsh_n[7:0], 8'h00};
            end
          end
        end
        S_CRC: begin
          if (mism)
            crc_bad <= 1'b1;
          if (c_cmd)
            crc7 <= {crc7[5:0], 1'b0};
          ccnt <= ccnt - 5'h01;
          if (ccnt == 5'h01)
            st <= after_crc;
        end
        S_STOP: begin
          if (!c_cmd && !fdat[0])
            e_stop <= 1'b1; // R18
          st <= S_END;
        end
        default: ;
      endcase
    end
    if (tick && st == S_END) begin
      st <= S_IDLE; // R23
      ready_req <= 1'b1; // R21
      if (crc_bad && c_cmd)
        e_c7 <= 1'b1; // R20
      if (crc_bad && !c_cmd)
        e_c16 <= 1'b1; // R19
    end
    if (st == S_REP && !rep)
      st <= S_IDLE;
    if ((st == S_IDLE) || (tick && st == S_END)) begin
      sd_cmd_oe_n <= 1'b1;
      sd_dat_oe_n <= 4'hF;
      sd_cmd_out <= 1'b1;
      sd_dat_out <= 4'hF;
    end
    if (busy && !c_cmd && !rep && !fcmd)
      cmdbrk <= 1'b1; // R16
  end
end

endmodule // sdhi_top

// ### sim/sdhi_checker.sv
// concurrent checks on the card host interface ports
`timescale 1ns/1ps
`include "sdhi_defs.vh"
module sdhi_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic sd_clk,
  input wire logic sd_cmd_oe_n,
  input wire logic [3:0] sd_dat_oe_n,
  input wire logic buffer_irq
);
  wire [15:0] idx = avs_address[17:2];
  wire mapped = (idx >= `SDHI_IDX_PTR && idx <= `SDHI_IDX_ST) || idx == `SDHI_IDX_IRQ;
  wire take = !avs_waitrequest;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> take)
    else $error("request left waiting");
  a_wait_single: assert property (take |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_upper_zero: assert property (avs_read && take |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_unmapped_zero: assert property (avs_read && take && !mapped |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_idle: assert property ($past(sys_rst) |-> !sd_clk && sd_cmd_oe_n && &sd_dat_oe_n)
    else $error("card lines busy after reset");
  a_lanes_legal: assert property (sd_dat_oe_n inside {4'hF, 4'hE, 4'h0})
    else $error("illegal data lane set driven");
  a_one_line: assert property (!sd_cmd_oe_n |-> &sd_dat_oe_n)
    else $error("command and data driven together");
  a_irq_clear: assert property (avs_write && take && idx == `SDHI_IDX_IRQ &&
    avs_byteenable[1] && !avs_writedata[14] |=> ##1 !buffer_irq)
    else $error("interrupt not masked");
  a_clk_high_max: assert property ($rose(sd_clk) |-> ##[1:32] !sd_clk)
    else $error("card clock high too long");
  a_mem_excl: assert property (!(mem_rd && mem_wr))
    else $error("memory read and write together");
  c_cmd_drive: cover property (!sd_cmd_oe_n);
  c_wide_drive: cover property (sd_dat_oe_n == 4'h0);
  c_irq_rise: cover property ($rose(buffer_irq));
endmodule // sdhi_checker

// ### sim/sdhi_card.sv
// card model: captures host frames, answers on the command line
`timescale 1ns/1ps
module sdhi_card (
  input wire logic sd_clk,
  input wire logic sd_cmd_out,
  input wire logic sd_cmd_oe_n,
  input wire logic [3:0] sd_dat_out,
  input wire logic [3:0] sd_dat_oe_n,
  input wire logic [16:0] resp,
  input wire logic resp_go,
  input wire logic dat_low,
  output logic sd_cmd_in,
  output logic [3:0] sd_dat_in
);
  logic [31:0] cbits = 32'h0;
  logic [31:0] dbits = 32'h0;
  int ccnt = 0;
  int dcnt = 0;
  int ri = 0;
  logic drv = 1'b1;
  // pull-ups hold every released line high
  assign sd_cmd_in = sd_cmd_oe_n ? drv : sd_cmd_out;
  // the card may hold data line zero low, as when busy
  assign sd_dat_in = ((~sd_dat_oe_n & sd_dat_out) | sd_dat_oe_n) & {3'b111, ~dat_low};
  always @(posedge sd_clk) begin
    if (!sd_cmd_oe_n) begin
      cbits <= {cbits[30:0], sd_cmd_out};
      ccnt <= ccnt + 1;
    end
    if (sd_dat_oe_n != 4'hF) begin
      dbits <= {dbits[27:0], sd_dat_out};
      dcnt <= dcnt + 1;
    end
  end
  // response bits change on the falling card clock edge
  always @(negedge sd_clk or negedge resp_go) begin
    if (!resp_go) begin
      ri <= 0;
      drv <= 1'b1;
    end else if (ri < 17) begin
      drv <= resp[16 - ri];
      ri <= ri + 1;
    end else begin
      drv <= 1'b1;
    end
  end
endmodule // sdhi_card

// ### sim/tb.sv
// testbench: register tasks, card frames and error flags
`timescale 1ns/1ps
`include "sdhi_defs.vh"
module tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [17:0] avs_address = 18'h00000;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [15:0] mem_rdata = 16'h0000;
  logic [16:0] resp = 17'h1FFFF;
  logic resp_go = 1'b0;
  logic dat_low = 1'b0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, mem_rd, mem_wr, sd_clk, sd_cmd_in, sd_cmd_out, sd_cmd_oe_n, buffer_irq;
  wire [10:0] mem_addr;
  wire [15:0] mem_wdata;
  wire [3:0] sd_dat_in, sd_dat_out, sd_dat_oe_n;
  logic [15:0] mem [0:2047];
  int miscompares = 0, n_tests = 0, n0 = 0, cyc = 0, last = 0, per = 0;
  sdhi_top dut (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata, .sd_clk, .sd_cmd_in, .sd_cmd_out, .sd_cmd_oe_n, .sd_dat_in,
    .sd_dat_out, .sd_dat_oe_n, .buffer_irq);
  sdhi_card card (.sd_clk, .sd_cmd_out, .sd_cmd_oe_n, .sd_dat_out, .sd_dat_oe_n, .resp,
    .resp_go, .dat_low, .sd_cmd_in, .sd_dat_in);
  initial forever #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge sd_clk) begin
    per = cyc - last;
    last = cyc;
  end
  always @(posedge clk) begin
    if (mem_rd) mem_rdata <= mem[mem_addr];
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
  // ----
  // bus and compare tasks
  // ----
  task automatic cmp(input logic [31:0] got, input logic [31:0] e);
    n_tests++;
    if (got !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic bus(input logic wr, input logic [15:0] ix, input logic [15:0] wd,
    output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= {ix, 2'b00};
    avs_writedata <= {16'h0000, wd};
    avs_byteenable <= 4'h3;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    cmp({31'h0, avs_waitrequest}, 32'h0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] ix, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, ix, d, r);
  endtask
  task automatic check(input logic [15:0] ix, input logic [15:0] m, input logic [15:0] e);
    logic [31:0] r;
    bus(1'b0, ix, 16'h0000, r);
    cmp(r & {16'hFFFF, m}, {16'h0000, e});
  endtask
  // launch, then poll until the engine reports idle
  task automatic go(input logic [15:0] cf);
    logic [31:0] r;
    int n;
    n = 0;
    wr(`SDHI_IDX_CFG, cf | 16'h0080);
    do begin
      bus(1'b0, `SDHI_IDX_CFG, 16'h0000, r);
      n++;
    end while (r[7] !== 1'b0 && n < 3000);
    cmp({31'h0, r[7]}, 32'h0);
  endtask
  function automatic logic [6:0] crc7(input logic [7:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 7; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? `SDHI_CRC7_POLY : 7'h00);
    return c;
  endfunction
  task conclude;
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    #100000;
    miscompares++;
    conclude;
  end
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(`SDHI_IDX_PTR, 16'hFFFF, 16'h0000);
    check(`SDHI_IDX_LEN, 16'hFFFF, 16'h0000);
    check(`SDHI_IDX_CFG, 16'hFFFF, 16'h0000);
    check(`SDHI_IDX_ST, 16'hFFFF, 16'h0010);
    check(16'hFC70, 16'hFFFF, 16'h0000);
    wr(`SDHI_IDX_PTR, 16'hFFFF);
    check(`SDHI_IDX_PTR, 16'hFFFF, 16'h07FF);
    // command write with checksum, then the ready request
    mem[11'h010] = 16'hA500;
    wr(`SDHI_IDX_PTR, 16'h0010);
    wr(`SDHI_IDX_LEN, 16'h0001);
    n0 = card.ccnt;
    go(16'h0022);
    cmp(card.ccnt - n0, 32'h11);
    cmp(card.cbits[16:0], {1'b0, 8'hA5, crc7(8'hA5), 1'b1});
    check(`SDHI_IDX_IRQ, 16'h0020, 16'h0020);
    cmp(buffer_irq, 1'b0);
    wr(`SDHI_IDX_IRQ, 16'h4000);
    repeat (3) @(posedge clk);
    cmp(buffer_irq, 1'b1);
    wr(`SDHI_IDX_IRQ, 16'h0020);
    check(`SDHI_IDX_IRQ, 16'h4020, 16'h0000);
    // wide data write without start, stop or checksum
    mem[11'h020] = 16'h3C96;
    wr(`SDHI_IDX_PTR, 16'h0020);
    wr(`SDHI_IDX_LEN, 16'h0002);
    n0 = card.dcnt;
    go(16'h141C);
    cmp(card.dcnt - n0, 32'h4);
    cmp(card.dbits[15:0], 16'h3C96);
    // data read that never starts while the command line chatters
    wr(`SDHI_IDX_ST, 16'h0500);
    wr(`SDHI_IDX_IRQ, 16'h0020);
    resp <= {1'b0, 8'h5A, crc7(8'h5A), 1'b1};
    resp_go <= 1'b1;
    go(16'h0041);
    resp_go <= 1'b0;
    check(`SDHI_IDX_ST, 16'h0021, 16'h0021);
    check(`SDHI_IDX_IRQ, 16'h0020, 16'h0000);
    // command responses with good and bad checksum
    for (int bad = 0; bad < 2; bad++) begin
      mem[11'h030] = 16'hFFFF;
      wr(`SDHI_IDX_PTR, 16'h0030);
      wr(`SDHI_IDX_LEN, 16'h0001);
      resp <= {1'b0, 8'h5A, crc7(8'h5A) ^ bad[6:0], 1'b1};
      resp_go <= 1'b1;
      go(16'h0063);
      resp_go <= 1'b0;
      cmp(mem[11'h030], 16'h5A00);
      check(`SDHI_IDX_ST, 16'h0023, {14'h0000, bad[0], 1'b0});
      cmp(per, 32'hC);
    end
    // data reads: released line zero fails the checksum, held low lacks the stop bit
    wr(`SDHI_IDX_PTR, 16'h0040);
    go(16'h0044);
    cmp(mem[11'h040], 16'hFF00);
    check(`SDHI_IDX_ST, 16'h003D, 16'h0014);
    dat_low <= 1'b1;
    go(16'h0040);
    cmp(mem[11'h040], 16'h0000);
    check(`SDHI_IDX_ST, 16'h003D, 16'h0008);
    dat_low <= 1'b0;
    // pattern replay on four lanes, region picked by pointer bits 10:8, wraps
    for (int i = 0; i < 256; i++)
      mem[11'h100 + i] = {i[7:0], ~i[7:0]};
    wr(`SDHI_IDX_IRQ, 16'h0020);
    wr(`SDHI_IDX_CFG, 16'h0400);
    wr(`SDHI_IDX_PTR, 16'h0137);
    n0 = card.dcnt;
    wr(`SDHI_IDX_ST, 16'h0080);
    for (int i = 0; i < 5000 && card.dcnt - n0 < 1028; i++)
      @(posedge clk);
    cmp(card.dbits, 32'hFF0000FF);
    wr(`SDHI_IDX_ST, 16'h0000);
    check(`SDHI_IDX_CFG, 16'h0080, 16'h0000);
    check(`SDHI_IDX_IRQ, 16'h0020, 16'h0000);
    conclude;
  end
endmodule // tb
bind sdhi_top sdhi_checker chk (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_rd, .mem_wr,
  .sd_clk, .sd_cmd_oe_n, .sd_dat_oe_n, .buffer_irq);
